/* File: hdl/ebsl_regs.vh */
// Register map, field positions, reset values and timing counts of the boot and safe-load block.
`ifndef EBSL_REGS_VH
`define EBSL_REGS_VH
`define EBSL_ADDR_W        10
`define EBSL_OFF_CTRL      10'h200
`define EBSL_OFF_DEVADDR   10'h316
`define EBSL_OFF_STARTADDR 10'h317
`define EBSL_CTRL_RST      16'h0000
`define EBSL_DEVADDR_RST   7'h50
`define EBSL_START_RST     16'h0000
`define EBSL_BIT_BOOT      15
`define EBSL_BIT_SL_TGT    5
`define EBSL_BIT_SL_PAR    4
`define EBSL_DEV_MSB       6
// I2C-style bit clock: the quarter period in system cycles, 20 MHz / (4 * 5) = 1 MHz bit rate.
`define EBSL_QTR_CYC       8'h05
`define EBSL_BOOT_WORDS    16'h0100
`endif

/* File: hdl/ebsl_bitgen.v */
// Divider that gives a one-cycle tick every quarter bit period of the boot memory link.
`timescale 1ns/1ns
`include "ebsl_regs.vh"
module ebsl_bitgen
(
  // Clock and reset
  input  wire       clk_in,
  input  wire       sys_rst_in,
  // Control
  input  wire       run_in,
  output reg        tick_out
);
  reg [7:0] count;
  always @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      count    <= 8'h00;
      tick_out <= 1'b0;
    end
    else if (!run_in)
    begin
      count    <= 8'h00;
      tick_out <= 1'b0;
    end
    else if (count == `EBSL_QTR_CYC - 8'h01)
    begin
      count    <= 8'h00;
      tick_out <= 1'b1;
    end
    else
    begin
      count    <= count + 8'h01;
      tick_out <= 1'b0;
    end
  end
endmodule // ebsl_bitgen

/* File: hdl/ebsl_ctrl.v */
// Boot loader and safe-load request control with register port and boot memory link.
// How it works
// RULE1 - Writing one to control bit 15 starts a self-boot, and zero means normal operation.
// RULE2 - Writing one to bit 5 requests a target/slew RAM safe load, cleared when it completes.
// RULE3 - Writing one to bit 4 requests a parameter RAM safe load, cleared when it completes.
// RULE4 - Software writes zeros to bits 14 to 6 and 3 to 0 of the control register.
// RULE5 - The 7-bit boot memory bus address sits in the low register bits and resets to 0x50.
// RULE6 - A 16-bit start address register sets where the boot read begins and resets to zero.
// RULE7 - In self-boot the block drives the bus and reads from the set device and start address.
`timescale 1ns/1ns
`include "ebsl_regs.vh"
module ebsl_ctrl
(
  // Clock and reset
  input  wire                    clk_in,
  input  wire                    sys_rst_in,
  // Register port
  input  wire [`EBSL_ADDR_W-1:0] addr_in,
  input  wire [15:0]             wdata_in,
  input  wire                    wr_in,
  input  wire                    rd_in,
  output reg  [15:0]             rdata_out,
  // Safe-load handshake with the core memories
  input  wire                    sl_tgt_done_in,
  input  wire                    sl_par_done_in,
  output reg                     sl_tgt_req_out,
  output reg                     sl_par_req_out,
  // Boot image words toward the core
  output reg  [7:0]              boot_data_out,
  output reg                     boot_valid_out,
  output reg                     boot_busy_out,
  // Boot memory two-wire link
  input  wire                    scl_in,
  output reg                     scl_out,
  output reg                     scl_oe_out,
  input  wire                    sda_in,
  output reg                     sda_out,
  output reg                     sda_oe_out
);
  localparam S_IDLE  = 6'b000001;
  localparam S_START = 6'b000010;
  localparam S_BYTE  = 6'b000100;
  localparam S_ACK   = 6'b001000;
  localparam S_RSTRT = 6'b010000;
  localparam S_STOP  = 6'b100000;

  reg        boot_en;
  reg        sl_tgt;
  reg        sl_par;
  reg [6:0]  dev_addr;
  reg [15:0] start_addr;
  reg [5:0]  state;
  reg [2:0]  phase_byte;
  reg [1:0]  quarter;
  reg [2:0]  bit_idx;
  reg [7:0]  shreg;
  reg [15:0] words_left;
  reg        reading;
  reg        sda_s1;
  reg        sda_s2;
  reg        scl_s1;
  reg        scl_s2;
  wire       tick;

  ebsl_bitgen u_bitgen
  (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .run_in     (state != S_IDLE),
    .tick_out   (tick)
  );

  function is_wr;
    input [`EBSL_ADDR_W-1:0] a;
    input [`EBSL_ADDR_W-1:0] off;
    begin
      is_wr = wr_in && (a == off);
    end
  endfunction

  // Link pins come from outside the clock domain.
  always @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
    end
    else
    begin
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
      scl_s1 <= scl_in;
      scl_s2 <= scl_s1;
    end
  end

  // A write that sets the bit wins over done in the same cycle; otherwise done clears it.
  always @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      sl_tgt         <= 1'b0;
      sl_par         <= 1'b0;
      dev_addr       <= `EBSL_DEVADDR_RST;
      start_addr     <= `EBSL_START_RST;
      sl_tgt_req_out <= 1'b0;
      sl_par_req_out <= 1'b0;
    end
    else
    begin
      if (is_wr(addr_in, `EBSL_OFF_CTRL) && wdata_in[`EBSL_BIT_SL_TGT])
        sl_tgt <= 1'b1; // RULE2
      else if (sl_tgt_done_in)
        sl_tgt <= 1'b0; // RULE2
      if (is_wr(addr_in, `EBSL_OFF_CTRL) && wdata_in[`EBSL_BIT_SL_PAR])
        sl_par <= 1'b1; // RULE3
      else if (sl_par_done_in)
        sl_par <= 1'b0; // RULE3
      if (is_wr(addr_in, `EBSL_OFF_DEVADDR))
        dev_addr <= wdata_in[`EBSL_DEV_MSB:0]; // RULE5
      if (is_wr(addr_in, `EBSL_OFF_STARTADDR))
        start_addr <= wdata_in; // RULE6
      sl_tgt_req_out <= sl_tgt;
      sl_par_req_out <= sl_par;
    end
  end

  // Read data stands one cycle after the strobe; unmapped offsets read zero.
  always @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      rdata_out <= 16'h0000;
    else if (rd_in)
    begin
      case (addr_in)
        `EBSL_OFF_CTRL:
          rdata_out <= {boot_en, 9'h000, sl_tgt, sl_par, 4'h0};
        `EBSL_OFF_DEVADDR:
          rdata_out <= {9'h000, dev_addr};
        `EBSL_OFF_STARTADDR:
          rdata_out <= start_addr;
        default:
          rdata_out <= 16'h0000;
      endcase
    end
    else
      rdata_out <= 16'h0000;
  end

  // Boot sequence: START, device write, start address high and low, repeated START,
  // device read, then a fixed number of bytes with ACK, NACK on the last, STOP.
  // Clock stretching by the memory is not supported; the link runs at a fixed rate.
  always @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      boot_en        <= 1'b0;
      state          <= S_IDLE;
      phase_byte     <= 3'h0;
      quarter        <= 2'h0;
      bit_idx        <= 3'h7;
      shreg          <= 8'h00;
      words_left     <= 16'h0000;
      reading        <= 1'b0;
      scl_out        <= 1'b0;
      scl_oe_out     <= 1'b0;
      sda_out        <= 1'b0;
      sda_oe_out     <= 1'b0;
      boot_data_out  <= 8'h00;
      boot_valid_out <= 1'b0;
      boot_busy_out  <= 1'b0;
    end
    else
    begin
      boot_valid_out <= 1'b0;
      if (is_wr(addr_in, `EBSL_OFF_CTRL))
        boot_en <= wdata_in[`EBSL_BIT_BOOT] | (boot_en & (state != S_IDLE)); // RULE1
      case (state)
        S_IDLE:
        begin
          scl_oe_out <= 1'b0;
          sda_oe_out <= 1'b0;
          boot_busy_out <= 1'b0;
          if (boot_en && !boot_busy_out)
          begin
            state         <= S_START; // RULE1
            boot_busy_out <= 1'b1;
            phase_byte    <= 3'h0;
            quarter       <= 2'h0;
            words_left    <= `EBSL_BOOT_WORDS;
            reading       <= 1'b0;
          end
        end
        S_START, S_RSTRT:
          if (tick)
          begin
            quarter <= quarter + 2'h1;
            case (quarter)
              2'h0:
              begin
                sda_oe_out <= 1'b0;
                scl_oe_out <= 1'b0;
              end
              2'h1:
                sda_oe_out <= 1'b1;
              2'h2:
                scl_oe_out <= 1'b1;
              default:
              begin
                bit_idx <= 3'h7;
                state   <= S_BYTE;
                if (state == S_RSTRT)
                  shreg <= {dev_addr, 1'b1}; // RULE7
                else
                  shreg <= {dev_addr, 1'b0}; // RULE7
                phase_byte <= (state == S_RSTRT) ? 3'h3 : 3'h0;
              end
            endcase
          end
        S_BYTE:
          if (tick)
          begin
            quarter <= quarter + 2'h1;
            case (quarter)
              2'h0:
                sda_oe_out <= reading ? 1'b0 : ~shreg[7];
              2'h1:
                scl_oe_out <= 1'b0;
              2'h2:
                if (reading)
                  shreg <= {shreg[6:0], sda_s2};
              default:
              begin
                scl_oe_out <= 1'b1;
                if (!reading)
                  shreg <= {shreg[6:0], 1'b0};
                bit_idx <= bit_idx - 3'h1;
                if (bit_idx == 3'h0)
                  state <= S_ACK;
              end
            endcase
          end
        S_ACK:
          if (tick)
          begin
            quarter <= quarter + 2'h1;
            case (quarter)
              2'h0:
                sda_oe_out <= reading && (words_left != 16'h0001);
              2'h1:
                scl_oe_out <= 1'b0;
              2'h2:
                if (reading)
                begin
                  boot_data_out  <= shreg;
                  boot_valid_out <= 1'b1;
                end
              default:
              begin
                scl_oe_out <= 1'b1;
                bit_idx    <= 3'h7;
                if (!reading && sda_s2)
                  state <= S_STOP;
                else if (reading)
                begin
                  words_left <= words_left - 16'h0001;
                  if (words_left == 16'h0001)
                    state <= S_STOP;
                  else
                    state <= S_BYTE;
                end
                else
                begin
                  phase_byte <= phase_byte + 3'h1;
                  case (phase_byte)
                    3'h0:
                    begin
                      shreg <= start_addr[15:8]; // RULE7
                      state <= S_BYTE;
                    end
                    3'h1:
                    begin
                      shreg <= start_addr[7:0]; // RULE7
                      state <= S_BYTE;
                    end
                    3'h2:
                      state <= S_RSTRT;
                    default:
                    begin
                      reading <= 1'b1;
                      state   <= S_BYTE;
                    end
                  endcase
                end
              end
            endcase
          end
        S_STOP:
          if (tick)
          begin
            quarter <= quarter + 2'h1;
            case (quarter)
              2'h0:
                sda_oe_out <= 1'b1;
              2'h1:
                scl_oe_out <= 1'b0;
              2'h2:
                sda_oe_out <= 1'b0;
              default:
              begin
                state   <= S_IDLE;
                boot_en <= 1'b0;
              end
            endcase
          end
        default:
          state <= S_IDLE;
      endcase
    end
  end
endmodule // ebsl_ctrl

/* File: testbench/ebsl_ctrl_monitor.sv */
// Checker of the boot and safe-load controller ports.
`timescale 1ns/1ns
module ebsl_ctrl_monitor
(
  // Clock, reset and register port
  input wire logic        clk_in,
  input wire logic        sys_rst_in,
  input wire logic [9:0]  addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic        wr_in,
  // Safe load, boot and link
  input wire logic        sl_tgt_done_in,
  input wire logic        sl_par_done_in,
  input wire logic        sl_tgt_req_out,
  input wire logic        sl_par_req_out,
  input wire logic        boot_valid_out,
  input wire logic        boot_busy_out,
  input wire logic        scl_oe_out,
  input wire logic        sda_oe_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  wire wc = wr_in && addr_in == 10'h200;
  par_req_a: assert property (wc && wdata_in[4] |-> ##2 sl_par_req_out)
    else $error("param request missing");
  tgt_req_a: assert property (wc && wdata_in[5] |-> ##2 sl_tgt_req_out)
    else $error("slew request missing");
  par_clr_a: assert property (sl_par_done_in && !wc |-> ##2 !sl_par_req_out)
    else $error("param request stuck");
  tgt_clr_a: assert property (sl_tgt_done_in && !wc |-> ##2 !sl_tgt_req_out)
    else $error("slew request stuck");
  req_hold_a: assert property (sl_par_req_out && !sl_par_done_in
    && !$past(sl_par_done_in) |=> sl_par_req_out) else $error("param request lost");
  boot_go_a: assert property (wc && wdata_in[15] |-> ##2 boot_busy_out)
    else $error("boot not started");
  link_idle_a: assert property (!boot_busy_out [*3] |-> !scl_oe_out && !sda_oe_out)
    else $error("link driven while idle");
  valid_one_a: assert property (boot_valid_out |-> boot_busy_out ##1 !boot_valid_out)
    else $error("bad byte strobe");
  c_par: cover property (sl_par_done_in && sl_par_req_out);
  c_tgt: cover property (sl_tgt_done_in && sl_tgt_req_out);
  c_boot: cover property ($fell(boot_busy_out));
endmodule // ebsl_ctrl_monitor

/* File: testbench/ebsl_eeprom_model.sv */
// Behavioural two-wire boot memory that returns the low address byte as data.
`timescale 1ns/1ns
module ebsl_eeprom_model
#(
  parameter logic [6:0] DEV = 7'h50
)
(
  // Link pins, the enable pulls data low
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_oe_out
);
  logic [7:0]  sh, cur;
  logic [15:0] ptr;
  int          bits, nb;
  logic        act = 1'b0, rd, ok, mack, tx;
  initial
    sda_oe_out = 1'b0;
  // A start or repeated start restarts the byte count.
  always @(negedge sda_in)
    if (scl_in)
    begin
      bits = 0;
      nb = 0;
      tx = 1'b0;
      act = 1'b1;
    end
  always @(posedge sda_in)
    if (scl_in)
      act = 1'b0;
  always @(posedge scl_in)
    if (act)
    begin
      if (bits < 8)
        sh = {sh[6:0], sda_in};
      else
        mack = !sda_in;
      bits++;
    end
  always @(negedge scl_in)
    if (act)
    begin
      if (bits == 8)
      begin
        if (nb == 0)
        begin
          ok = sh[7:1] == DEV;
          rd = sh[0];
        end
        if (!rd && nb == 1)
          ptr[15:8] = sh;
        if (!rd && nb == 2)
          ptr[7:0] = sh;
        sda_oe_out = ok && !(rd && nb > 0);
      end
      else if (bits == 9)
      begin
        bits = 0;
        nb++;
        tx = rd && ok && (nb == 1 || mack);
        cur = ptr[7:0];
        if (tx)
          ptr = ptr + 16'h0001;
        sda_oe_out = tx && !cur[7];
      end
      else if (tx)
        sda_oe_out = !cur[7-bits];
    end
endmodule // ebsl_eeprom_model

/* File: testbench/ebsl_ctrl_bench.sv */
// Self-checking bench of the boot and safe-load controller.
`timescale 1ns/1ns
module ebsl_ctrl_bench;
  logic        clk_in = 1'b0, sys_rst_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0;
  logic        sl_tgt_done_in = 1'b0, sl_par_done_in = 1'b0;
  logic [9:0]  addr_in = 10'h000;
  logic [15:0] wdata_in = 16'h0000;
  logic [7:0]  exp_b;
  wire  [15:0] rdata_out;
  wire  [7:0]  boot_data_out;
  wire         sl_tgt_req_out, sl_par_req_out, boot_valid_out, boot_busy_out;
  wire         scl_oe_out, sda_oe_out, mem_oe, scl_o, sda_o;
  // Both link lines have pull-ups, so a released line reads high.
  wire         scl_w = ~scl_oe_out;
  wire         sda_w = ~(sda_oe_out | mem_oe);
  int          err_total = 0, compares = 0, nbytes = 0;
  always #25 clk_in = ~clk_in;
  ebsl_ctrl dut (.clk_in, .sys_rst_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .sl_tgt_done_in, .sl_par_done_in, .sl_tgt_req_out, .sl_par_req_out, .boot_data_out,
    .boot_valid_out, .boot_busy_out, .scl_in(scl_w), .scl_out(scl_o), .scl_oe_out,
    .sda_in(sda_w), .sda_out(sda_o), .sda_oe_out);
  ebsl_eeprom_model mem (.scl_in(scl_w), .sda_in(sda_w), .sda_oe_out(mem_oe));
  task chk(input logic [15:0] s, input logic [15:0] e);
    compares++;
    if (s !== e)
    begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, s, e);
    end
  endtask
  task wr(input logic [9:0] a, input logic [15:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task rd(input logic [9:0] a, input logic [15:0] e);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 chk(rdata_out, e);
  endtask
  task pulse(input logic tgt);
    @(posedge clk_in);
    sl_tgt_done_in <= tgt;
    sl_par_done_in <= !tgt;
    @(posedge clk_in);
    sl_tgt_done_in <= 1'b0;
    sl_par_done_in <= 1'b0;
  endtask
  task wait_idle(input int lim);
    for (int n = 0; boot_busy_out !== 1'b0 && n < lim; n++)
      @(posedge clk_in);
    chk(boot_busy_out, 1'b0);
    // Open-drain lines: the driven level must always be low, only the enables move.
    chk({scl_o, sda_o}, 16'h0000);
  endtask
  // Every boot byte is checked as it passes; data is the low memory address byte.
  always @(negedge clk_in)
    if (boot_valid_out === 1'b1)
    begin
      chk(boot_data_out, exp_b);
      exp_b = exp_b + 8'h01;
      nbytes++;
    end
  task t_regs;
    rd(10'h200, 16'h0000);
    rd(10'h316, 16'h0050);
    rd(10'h317, 16'h0000);
    wr(10'h317, 16'hffff);
    rd(10'h317, 16'hffff);
    wr(10'h100, 16'h1234);
    rd(10'h100, 16'h0000);
  endtask
  task t_safe;
    wr(10'h200, 16'h0030);
    rd(10'h200, 16'h0030);
    chk({sl_tgt_req_out, sl_par_req_out}, 16'h0003);
    wr(10'h200, 16'h0000);
    rd(10'h200, 16'h0030);
    pulse(1'b0);
    rd(10'h200, 16'h0020);
    chk(sl_par_req_out, 16'h0000);
    pulse(1'b1);
    rd(10'h200, 16'h0000);
    chk(sl_tgt_req_out, 16'h0000);
  endtask
  // A device address the memory does not own must end the boot with no bytes.
  task t_nack;
    wr(10'h316, 16'h0051);
    rd(10'h316, 16'h0051);
    wr(10'h200, 16'h8000);
    rd(10'h200, 16'h8000);
    wait_idle(3000);
    chk(nbytes[15:0], 16'h0000);
    rd(10'h200, 16'h0000);
    wr(10'h316, 16'h0050);
  endtask
  task t_boot;
    wr(10'h317, 16'h12f0);
    exp_b = 8'hf0;
    wr(10'h200, 16'h8000);
    rd(10'h200, 16'h8000);
    wait_idle(60000);
    chk(nbytes[15:0], 16'h0100);
    chk(mem.ptr, 16'h13f0);
    rd(10'h200, 16'h0000);
  endtask
  task test_done;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    t_regs;
    t_safe;
    t_nack;
    t_boot;
    test_done;
  end
  // The boot of 256 bytes takes about 47000 cycles.
  initial
  begin
    repeat (80000) @(posedge clk_in);
    err_total++;
    test_done;
  end
endmodule // ebsl_ctrl_bench
bind ebsl_ctrl ebsl_ctrl_monitor mon (.clk_in, .sys_rst_in, .addr_in, .wdata_in, .wr_in,
  .sl_tgt_done_in, .sl_par_done_in, .sl_tgt_req_out, .sl_par_req_out, .boot_valid_out,
  .boot_busy_out, .scl_oe_out, .sda_oe_out);
